// ---- rtl/bfp_count.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Down counter: loads a count, flags when it reaches zero
module bfp_count #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         nrst_in,
    // Control
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    output logic              zero_out
);

    logic [W-1:0] count;

    // Load wins over counting
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            count <= '0;
        end else if (load_in) begin
            count <= value_in;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign zero_out = (count == '0);

endmodule

`default_nettype wire

// ---- rtl/bfp_host.sv ----
`timescale 1ns/100ps
`default_nettype none

// Function
// - Controller meets access time and holds data through setup
// - Write completes in one bus cycle; next access may follow
// - Controller holds chip select high for precharge minimum
// - Controller never exceeds maximum chip select low time
// - Every access gets a fresh falling edge of chip select
// - Chip select does not fall while synchronised supply is not good; an access under way runs to its end
// - Write strobe does not fall while synchronised supply is not good; a write under way runs to its end
module bfp_host #(
    parameter int ACCESS_CYC     = bfp_pkg::ACCESS_CYC,
    parameter int PRECHARGE_CYC  = bfp_pkg::PRECHARGE_CYC,
    parameter int CE_LOW_MAX_CYC = bfp_pkg::CE_LOW_MAX_CYC
) (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   nrst_in,
    // Supply status
    input  wire logic                   power_good_in,
    // User request
    input  wire logic                   req_valid_in,
    input  wire bfp_pkg::bfp_req_t      req_in,
    output logic                        req_ready_out,
    // User answer
    output logic                        rsp_valid_out,
    output logic [7:0]                  rsp_rdata_out,
    // Device pins
    output bfp_pkg::bfp_pins_t          pins_out,
    input  wire logic [7:0]             data_lines_in,
    output logic [7:0]                  data_lines_out,
    output logic [7:0]                  data_lines_oe_n_out
);

    // ==========================================================
    // Parameter checks
    // Select stays low ACCESS_CYC + 4 cycles, which must fit the device limit
    if (ACCESS_CYC < 1 || PRECHARGE_CYC < 1 || ACCESS_CYC + 4 > CE_LOW_MAX_CYC ||
        CE_LOW_MAX_CYC > 65535 || PRECHARGE_CYC > 65536) begin : g_bad_timing
        $error("bfp_host: timing parameters out of range");
    end

    // ==========================================================
    // State machine
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ACCESS = 4'b0010,
        ST_LAST   = 4'b0100,
        ST_PRECH  = 4'b1000
    } bfp_state_t;

    bfp_state_t state;
    bfp_state_t next_state;
    logic       is_write;
    logic [7:0] wdata;
    logic       timer_load;
    logic [15:0] timer_value;
    logic       timer_zero;
    logic [7:0] din_meta;
    logic [7:0] din_sync;
    logic       pg_meta;
    logic       pg_sync;

    // ==========================================================
    // Input synchronisers
    // Pin inputs pass two flip-flops before anything reads them
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            din_meta <= 8'h00;
            din_sync <= 8'h00;
            pg_meta  <= 1'b0;
            pg_sync  <= 1'b0;
        end else begin
            din_meta <= data_lines_in;
            din_sync <= din_meta;
            pg_meta  <= power_good_in;
            pg_sync  <= pg_meta;
        end
    end

    // ==========================================================
    // Cycle timer
    // Access timer also covers the two-flop data sampling delay
    bfp_count #(
        .W (16)
    ) u_timer (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .load_in     (timer_load),
        .value_in    (timer_value),
        .zero_out    (timer_zero)
    );

    // Single timing profile for reads and writes
    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = 16'h0000;
        case (state)
            ST_IDLE: begin
                if (req_valid_in && pg_sync) begin
                    next_state  = ST_ACCESS;
                    timer_load  = 1'b1;
                    timer_value = 16'(ACCESS_CYC + 2);
                end
            end
            ST_ACCESS: begin
                if (timer_zero) begin
                    next_state = ST_LAST;
                end
            end
            ST_LAST: begin
                // Precharge count starts as select rises
                next_state  = ST_PRECH;
                timer_load  = 1'b1;
                timer_value = 16'(PRECHARGE_CYC - 1);
            end
            ST_PRECH: begin
                if (timer_zero) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Request capture and pin drivers
    // Request kind and data kept for the rest of the cycle
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            is_write <= 1'b0;
            wdata    <= 8'h00;
        end else if (state == ST_IDLE && next_state == ST_ACCESS) begin
            is_write <= req_in.write;
            wdata    <= req_in.wdata;
        end
    end

    // Strobes: select low only in access states, so each cycle has a
    // fresh falling edge and a bounded low time
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pins_out.chip_select_n  <= 1'b1;
            pins_out.write_strobe_n <= 1'b1;
            pins_out.output_drive_n <= 1'b1;
            pins_out.address_lines  <= 13'h0000;
        end else begin
            // Address moves only at a take; one process owns the whole pin struct
            if (state == ST_IDLE && next_state == ST_ACCESS) begin
                pins_out.address_lines <= req_in.addr;
            end
            pins_out.chip_select_n  <= !(next_state == ST_ACCESS ||
                                         next_state == ST_LAST);
            // Write strobe falls with select: select-controlled write
            pins_out.write_strobe_n <= !((next_state == ST_ACCESS || next_state == ST_LAST) &&
                                         ((state == ST_IDLE) ? req_in.write : is_write));
            pins_out.output_drive_n <= !((next_state == ST_ACCESS || next_state == ST_LAST) &&
                                         !((state == ST_IDLE) ? req_in.write : is_write));
        end
    end

    // Data lines driven only during writes; data stays stable to strobe rise
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            data_lines_out      <= 8'h00;
            data_lines_oe_n_out <= 8'hff;
        end else if (state == ST_IDLE && next_state == ST_ACCESS && req_in.write) begin
            data_lines_out      <= req_in.wdata;
            data_lines_oe_n_out <= 8'h00;
        end else if (state == ST_LAST || (state == ST_IDLE && next_state != ST_ACCESS)) begin
            data_lines_out      <= wdata;
            data_lines_oe_n_out <= 8'hff;
        end
    end

    // ==========================================================
    // User answer
    // Read answer: sampled at end of access, after the sync delay
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 8'h00;
        end else begin
            rsp_valid_out <= (state == ST_LAST) && !is_write;
            if (state == ST_LAST && !is_write) begin
                rsp_rdata_out <= din_sync;
            end
        end
    end

    // Ready only while idle and supply good
    assign req_ready_out = (state == ST_IDLE) && pg_sync;

endmodule

`default_nettype wire

// ---- rtl/bfp_pkg.sv ----
`default_nettype none

package bfp_pkg;

    // ==========================================================
    // Array geometry
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 8;
    localparam int DEPTH       = 8192;
    localparam int ROW_BYTES   = 8;
    localparam int ROW_COUNT   = 1024;

    // ==========================================================
    // Timing in ns and derived cycle counts at 250 MHz
    localparam int CLK_PERIOD_PS         = 4000;
    localparam int ACCESS_TIME_NS        = 70;
    localparam int PRECHARGE_MIN_TIME_NS = 60;
    localparam int CE_LOW_MAX_NS         = 10000;
    localparam int DATA_SETUP_NS         = 30;
    // Least times round up
    localparam int ACCESS_CYC    = (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC =
        (PRECHARGE_MIN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC     = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest time rounds down
    localparam int CE_LOW_MAX_CYC = (CE_LOW_MAX_NS * 1000) / CLK_PERIOD_PS;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic              write;
        logic [12:0]       addr;
        logic [7:0]        wdata;
    } bfp_req_t;

    typedef struct packed {
        logic              chip_select_n;
        logic              write_strobe_n;
        logic              output_drive_n;
        logic [12:0]       address_lines;
    } bfp_pins_t;

endpackage

`default_nettype wire

// ---- test/bfp_fram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============
// Memory device, sampled at the core clock
module bfp_fram_model #(
    parameter int ACC = 2 // One access time for both kinds
) (
    // Pins and bus
    input  wire logic               core_clk_in,
    input  wire bfp_pkg::bfp_pins_t pins_in,
    input  wire logic [7:0]         bus_in,
    output logic                    drive_out,
    output logic [7:0]              data_out
);
    logic [7:0]         mem [8192]; // Rows only wear, so flat
    bfp_pkg::bfp_pins_t prev;
    logic [12:0]        addr;
    logic [7:0]         wdat;
    logic               wr;
    int                 age;
    wire logic go = prev.chip_select_n && !pins_in.chip_select_n;
    // Never blocks by itself; write lands at first strobe rise
    always_ff @(posedge core_clk_in) begin
        prev <= pins_in;
        age <= go ? 0 : age + 1;
        addr <= go ? pins_in.address_lines : addr;
        wr <= go ? !pins_in.write_strobe_n : (wr | !pins_in.write_strobe_n);
        wdat <= bus_in;
        if (!prev.chip_select_n && !prev.write_strobe_n && wr && age >= ACC
            && (pins_in.chip_select_n || pins_in.write_strobe_n)) begin
            mem[addr] <= wdat;
        end
    end
    // Drives only when selected, reading and data ready; a fresh cycle waits
    assign drive_out = !pins_in.chip_select_n && !pins_in.output_drive_n && !go
        && pins_in.write_strobe_n && !wr && age >= ACC;
    assign data_out = mem[addr];
endmodule
`default_nettype wire

// ---- test/bfp_host_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============
// Host pin checker
module bfp_host_asserts #(
    parameter int ACCESS_CYC     = 2,
    parameter int PRECHARGE_CYC  = 1,
    parameter int CE_LOW_MAX_CYC = 10
) (
    // Clock, reset, supply
    input wire logic               core_clk_in,
    input wire logic               nrst_in,
    input wire logic               power_good_in,
    // User side
    input wire logic               req_valid_in,
    input wire bfp_pkg::bfp_req_t  req_in,
    input wire logic               req_ready_out,
    input wire logic               rsp_valid_out,
    // Pins
    input wire bfp_pkg::bfp_pins_t pins_out,
    input wire logic [7:0]         data_lines_out,
    input wire logic [7:0]         data_lines_oe_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic cs = pins_out.chip_select_n;
    wire logic we = pins_out.write_strobe_n;
    wire logic od = pins_out.output_drive_n;
    int lo, hi;
    // Run lengths of select; too long for a repetition count
    always_ff @(posedge core_clk_in) begin
        lo <= (cs || !nrst_in) ? 0 : lo + 1;
        hi <= !nrst_in ? PRECHARGE_CYC : (cs ? hi + 1 : 0);
    end
    sequence s_take; req_valid_in && req_ready_out; endsequence
    sequence s_open; $fell(cs) && pins_out.address_lines == $past(req_in.addr); endsequence
    property p_open; s_take |=> s_open; endproperty
    property p_wr; s_take ##0 req_in.write |=> !we && od && data_lines_oe_n_out == 8'h00
        && data_lines_out == $past(req_in.wdata); endproperty
    property p_rd; s_take ##0 !req_in.write |=> we && !od && data_lines_oe_n_out == 8'hff;
        endproperty
    property p_hold; !we && !$past(we) |-> $stable(data_lines_out); endproperty
    property p_len; $rose(cs) |-> lo == ACCESS_CYC + 4; endproperty
    property p_pc; $fell(cs) |-> hi >= PRECHARGE_CYC; endproperty
    property p_ans; rsp_valid_out == $rose(od); endproperty
    property p_pwr; !power_good_in [*4] |-> !$fell(cs) && !$fell(we); endproperty
    property p_lmax; lo <= CE_LOW_MAX_CYC; endproperty
    a_open: assert property (p_open) else $error("no select fall");
    a_wr: assert property (p_wr) else $error("bad write start");
    a_rd: assert property (p_rd) else $error("bad read start");
    a_hold: assert property (p_hold) else $error("write data moved");
    a_len: assert property (p_len) else $error("access length");
    a_pc: assert property (p_pc) else $error("precharge short");
    a_ans: assert property (p_ans) else $error("answer timing");
    a_pwr: assert property (p_pwr) else $error("access with supply low");
    a_lmax: assert property (p_lmax) else $error("select low too long");
endmodule
bind bfp_host bfp_host_asserts #(.ACCESS_CYC(ACCESS_CYC), .PRECHARGE_CYC(PRECHARGE_CYC),
    .CE_LOW_MAX_CYC(CE_LOW_MAX_CYC)) u_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .power_good_in(power_good_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .pins_out(pins_out),
    .data_lines_out(data_lines_out), .data_lines_oe_n_out(data_lines_oe_n_out));
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    // Bench signals
    logic               clk = 1'b0, nrst = 1'b0, pg = 1'b0, rv = 1'b0;
    logic               rdy, rspv, drv;
    logic [7:0]         rdat, dout, doe_n, dq, last = 8'h00;
    bfp_pkg::bfp_req_t  rq = '0;
    bfp_pkg::bfp_pins_t pins;
    int                 err_count = 0, checks = 0, cyc = 0;
    // Released lines show the inverse of their last level: nothing pulls them
    wire logic [7:0]    bus = (~doe_n & dout) | (doe_n & (drv ? dq : ~last));
    wire logic [2:0]    idle = {rdy, pins.chip_select_n, pins.write_strobe_n};
    localparam int ACC = 2, PRE = 1, LMAX = 10;
    bfp_host #(.ACCESS_CYC(ACC), .PRECHARGE_CYC(PRE), .CE_LOW_MAX_CYC(LMAX)) uut (
        .core_clk_in(clk), .nrst_in(nrst), .power_good_in(pg), .req_valid_in(rv),
        .req_in(rq), .req_ready_out(rdy), .rsp_valid_out(rspv), .rsp_rdata_out(rdat),
        .pins_out(pins), .data_lines_in(bus), .data_lines_out(dout),
        .data_lines_oe_n_out(doe_n));
    bfp_fram_model #(.ACC(ACC)) dev (
        .core_clk_in(clk), .pins_in(pins), .bus_in(bus), .drive_out(drv), .data_out(dq));
    // Clock, and a ceiling far above the roughly 115 cycles used
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        last <= bus;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request; for reads d is the expected byte
    task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        rv = 1'b1;
        rq = '{w, a, d};
        while (rdy !== 1'b1 && n < 99) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        rv = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!w && rspv !== 1'b1 && n < 30);
        if (!w) begin
            // Answer shows as select rises, after ACC + 4 low cycles
            cmp("read latency", 16'(ACC + 4), 16'(n));
            cmp("read data", {8'h00, d}, {8'h00, rdat});
        end
    endtask
    // Supply low: requests wait, select and write strobe stay high
    task automatic t_power();
        pg = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rv = 1'b1;
        repeat (12) begin
            @(posedge clk);
            #1;
            cmp("idle pins", 16'h0003, {13'h0000, idle});
        end
        rv = 1'b0;
        pg = 1'b1;
        @(posedge clk);
        #1;
        $display("t_power done");
    endtask
    // Row edges, top address, an overwrite, read right after write
    task automatic t_rows();
        logic [12:0] a [5] = '{13'h0000, 13'h0007, 13'h0008, 13'h1fff, 13'h0000};
        for (int i = 0; i < 5; i++) op(1'b1, a[i], 8'h3c + 8'(i));
        for (int i = 1; i < 5; i++) op(1'b0, a[i], 8'h3c + 8'(i));
        $display("t_rows done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Reset for ten cycles, then the tests
    initial begin
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_power();
        t_rows();
        t_power();
        report_and_stop();
    end
endmodule
`default_nettype wire
